// ### src/optical_pkg.sv
package optical_pkg;
  // timing, figures as printed, derived at the 200 MHz sys_clk
  localparam int CLK_MHZ = 200;
  localparam int T_ON_MS = 1;
  localparam int T_OFF_US = 10;
  localparam int T_INIT_MS = 300;
  localparam int T_FAULT_US = 100;
  localparam int T_RESET_US = 10;
  localparam int T_LOS_US = 100;
  localparam int F_SCL_MAX_KHZ = 400;
  localparam int ON_CYCLES = T_ON_MS * 1000 * CLK_MHZ;
  localparam int OFF_CYCLES = T_OFF_US * CLK_MHZ;
  localparam int INIT_CYCLES = T_INIT_MS * 1000 * CLK_MHZ;
  localparam int FAULT_CYCLES = T_FAULT_US * CLK_MHZ;
  localparam int RESET_CYCLES = (T_RESET_US * CLK_MHZ + 0);
  localparam int LOS_CYCLES = T_LOS_US * CLK_MHZ;
  localparam int SCL_HALF_CYCLES = (CLK_MHZ * 1000) / (2 * F_SCL_MAX_KHZ);
  localparam logic [11:0] RESET_COUNT = 12'(RESET_CYCLES);
  // two-wire map
  localparam logic [6:0] ID_DEV_ADDR = 7'h50;
  localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
  localparam logic [7:0] ID_TYPE_ADDR = 8'h00;
  localparam logic [7:0] CAL_ADDR = 8'h5c;
  localparam int CAL_INT_BIT = 5;
  localparam int CAL_EXT_BIT = 4;
  localparam logic [7:0] DIAG_BASE = 8'h60;
  localparam int DIAG_BYTES = 10;
  localparam logic [7:0] STATUS_ADDR = 8'h6e;
  localparam int ST_TXDIS_BIT = 7;
  localparam int ST_SOFTDIS_BIT = 6;
  localparam int ST_FAULT_BIT = 2;
  localparam int ST_LOS_BIT = 1;
  localparam int ST_NOTRDY_BIT = 0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  typedef enum logic [2:0] {
    TW_IDLE, TW_ADDR, TW_ACK_ADDR, TW_WRITE, TW_ACK_WRITE, TW_READ, TW_ACK_READ
  } twi_state_t;
endpackage

// ### src/optical_module_control_status.sv
`timescale 1ns/1ps
// Notes on behaviour
// RL1: once the laser disable request is released the laser output returns within 1 ms.
// RL2: once the laser disable request is raised the laser output stops within 10 us.
// RL3: after reset, initialisation ends and the fault indication is cleared within 300 ms.
// RL4: a laser fault raises the fault indication within 100 us; disable held 10 us clears it.
// RL5: the fault pin is pulled low in normal operation and released high on a fault.
// RL6: the signal-lost pin follows loss of signal, both ways, within 100 us.
// RL7: the laser runs only while the disable input is low; high or floating disables it.
// RL8: the serial clock from the host stays at or below 400 kHz.
// RL9: the presence pin is held at ground.
// RL10: one pin is the serial clock and one the serial data line for reading the module.
// RL11: temperature, supply, bias, transmit and receive power are monitored and readable.
// RL12: identification sits at serial address 50h and diagnostics at 51h in the usual layout.
module optical_module_control_status #(
  parameter int INIT_CYCLES = optical_pkg::INIT_CYCLES,
  parameter logic [7:0] ID_TYPE = 8'h5a // arbitrary value
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // host pins
  input wire logic tx_disable_pin,
  output logic tx_fault_out,
  output logic tx_fault_oe,
  output logic receive_signal_lost_out,
  output logic receive_signal_lost_oe,
  output logic presence_out,
  output logic presence_oe,
  // two-wire serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // optics side
  input wire logic laser_fault_in,
  input wire logic rx_signal_absent_in,
  output logic laser_on,
  // monitors and calibration mode
  input wire logic cal_external,
  input wire logic [15:0] diag_temp,
  input wire logic [15:0] diag_vcc,
  input wire logic [15:0] diag_bias,
  input wire logic [15:0] diag_tx_power,
  input wire logic [15:0] diag_rx_power
);
  logic [1:0] dis_sync, flt_sync, los_sync, scl_sync, sda_sync;
  logic scl_d, sda_d;
  logic init_done, tx_fault, receive_signal_lost, soft_disable;
  logic [31:0] init_cnt;
  logic [11:0] disable_cnt;
  logic [7:0] diag_mem [0:optical_pkg::DIAG_BYTES-1];
  optical_pkg::twi_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shift, ptr;
  logic page, rw, first_byte, nacked;

  always_ff @(posedge sys_clk) begin
    dis_sync <= {dis_sync[0], tx_disable_pin};
    flt_sync <= {flt_sync[0], laser_fault_in};
    los_sync <= {los_sync[0], rx_signal_absent_in};
    scl_sync <= {scl_sync[0], scl_in}; // RL8
    sda_sync <= {sda_sync[0], sda_in};
    scl_d <= scl_sync[1];
    sda_d <= sda_sync[1];
  end

  wire tx_disable_s = dis_sync[1];
  wire laser_fault_s = flt_sync[1];
  wire rx_lost_s = los_sync[1];
  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire twi_start = scl_s & scl_d & sda_d & ~sda_s;
  wire twi_stop = scl_s & scl_d & ~sda_d & sda_s;
  wire disable_held = (disable_cnt == optical_pkg::RESET_COUNT);
  // a fault always forces the laser dark until a held disable, or the end of init, clears it
  wire disable_req = tx_disable_s | soft_disable | ~init_done | tx_fault;
  wire [7:0] rx_byte = {shift[6:0], sda_s};
  // address match taken from the completed byte held in shift
  wire addr_hit_q = (shift[7:1] == optical_pkg::ID_DEV_ADDR) |
                    (shift[7:1] == optical_pkg::DIAG_DEV_ADDR);
  wire [79:0] diag_all = {diag_temp, diag_vcc, diag_bias, diag_tx_power, diag_rx_power};
  wire [7:0] status_byte = {tx_disable_s, soft_disable, 3'h0, tx_fault,
                            receive_signal_lost, ~init_done};
  wire [7:0] cal_byte = 8'(cal_external) << optical_pkg::CAL_EXT_BIT |
                        8'(~cal_external) << optical_pkg::CAL_INT_BIT;

  // byte seen by the host at the pointer of the selected page
  function automatic logic [7:0] mem_byte(input logic pg, input logic [7:0] a);
    logic [7:0] b;
    b = 8'h00;
    if (!pg) begin
      if (a == optical_pkg::ID_TYPE_ADDR) b = ID_TYPE;
      else if (a == optical_pkg::CAL_ADDR) b = cal_byte;
    end else if (a - optical_pkg::DIAG_BASE < 8'(optical_pkg::DIAG_BYTES)) begin
      b = diag_mem[4'(a - optical_pkg::DIAG_BASE)];
    end else if (a == optical_pkg::STATUS_ADDR) begin
      b = status_byte;
    end
    return b;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      init_cnt <= 32'h0000_0000;
      init_done <= 1'b0;
    end else if (!init_done) begin
      init_cnt <= init_cnt + 32'h0000_0001;
      init_done <= (init_cnt == 32'(INIT_CYCLES - 1)); // RL3
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      disable_cnt <= 12'h000;
    end else if (!tx_disable_s) begin
      disable_cnt <= 12'h000;
    end else if (!disable_held) begin
      disable_cnt <= disable_cnt + 12'h001; // RL4
    end
  end

  // fault set wins over the disable-held clear
  always_ff @(posedge sys_clk) begin
    if (srst) tx_fault <= 1'b1;
    else if (laser_fault_s) tx_fault <= 1'b1; // RL4
    // fault held through init, a long disable cannot clear it early
    else if ((disable_held && init_done) ||
             (init_cnt == 32'(INIT_CYCLES - 1) && !init_done)) begin
      tx_fault <= 1'b0; // RL3 RL4
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      laser_on <= 1'b0;
      receive_signal_lost <= 1'b0;
    end else begin
      laser_on <= ~disable_req; // RL1 RL2 RL7
      receive_signal_lost <= rx_lost_s; // RL6
    end
  end

  // open-collector pins: pull low for logic 0, release for logic 1
  assign tx_fault_out = 1'b0;
  assign tx_fault_oe = ~tx_fault; // RL5
  assign receive_signal_lost_out = 1'b0;
  assign receive_signal_lost_oe = ~receive_signal_lost; // RL6
  assign presence_out = 1'b0;
  assign presence_oe = 1'b1; // RL9
  assign sda_out = 1'b0;
  assign sda_oe = (state == optical_pkg::TW_ACK_ADDR) |
                  (state == optical_pkg::TW_ACK_WRITE) |
                  ((state == optical_pkg::TW_READ) & ~shift[7]); // RL10

  // monitors frozen at each start so multi-byte values read coherently
  always_ff @(posedge sys_clk) begin
    if (twi_start) begin
      for (int i = 0; i < optical_pkg::DIAG_BYTES; i++) begin
        diag_mem[i] <= diag_all[79 - 8 * i -: 8]; // RL11
      end
    end
  end

  // two-wire slave, sampled on the synchronised scl; needs scl well below sys_clk
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= optical_pkg::TW_IDLE;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      ptr <= 8'h00;
      page <= 1'b0;
      rw <= 1'b0;
      first_byte <= 1'b0;
      nacked <= 1'b0;
      soft_disable <= 1'b0;
    end else if (twi_start) begin
      state <= optical_pkg::TW_ADDR;
      bitcnt <= 4'h0;
    end else if (twi_stop) begin
      state <= optical_pkg::TW_IDLE;
    end else begin
      unique case (state)
        optical_pkg::TW_IDLE: begin
        end
        optical_pkg::TW_ADDR, optical_pkg::TW_WRITE: begin
          if (scl_rise) begin
            shift <= rx_byte;
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == optical_pkg::BYTE_BITS) begin
            if (state == optical_pkg::TW_ADDR) begin
              page <= shift[1];
              rw <= shift[0];
              first_byte <= 1'b1;
              state <= addr_hit_q ? optical_pkg::TW_ACK_ADDR : optical_pkg::TW_IDLE; // RL12
            end else begin
              state <= optical_pkg::TW_ACK_WRITE;
              first_byte <= 1'b0;
              if (first_byte) begin
                ptr <= shift;
              end else begin
                if (page && ptr == optical_pkg::STATUS_ADDR) begin
                  soft_disable <= shift[optical_pkg::ST_SOFTDIS_BIT];
                end
                ptr <= ptr + 8'h01;
              end
            end
          end
        end
        optical_pkg::TW_ACK_ADDR, optical_pkg::TW_ACK_WRITE: begin
          if (scl_fall) begin
            bitcnt <= 4'h0;
            if (state == optical_pkg::TW_ACK_ADDR && rw) begin
              state <= optical_pkg::TW_READ;
              shift <= mem_byte(page, ptr); // RL10 RL12
            end else begin
              state <= optical_pkg::TW_WRITE;
            end
          end
        end
        optical_pkg::TW_READ: begin
          if (scl_rise) begin
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt == optical_pkg::BYTE_BITS) begin
              state <= optical_pkg::TW_ACK_READ;
              ptr <= ptr + 8'h01;
            end else begin
              shift <= {shift[6:0], 1'b0};
            end
          end
        end
        optical_pkg::TW_ACK_READ: begin
          if (scl_rise) begin
            nacked <= sda_s;
          end else if (scl_fall) begin
            bitcnt <= 4'h0;
            state <= nacked ? optical_pkg::TW_IDLE : optical_pkg::TW_READ;
            shift <= mem_byte(page, ptr);
          end
        end
      endcase
    end
  end

  // whole frozen snapshot, so every monitor word is watched
  wire [79:0] snap_all = {diag_mem[0], diag_mem[1], diag_mem[2], diag_mem[3], diag_mem[4],
                          diag_mem[5], diag_mem[6], diag_mem[7], diag_mem[8], diag_mem[9]};

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_off; tx_disable_s |=> !laser_on; endproperty
  a_off: assert property (p_off) else $error("laser on while disabled"); // RL2
  property p_on;
    $fell(tx_disable_s) && !soft_disable && init_done && !tx_fault && !laser_fault_s
      |=> laser_on;
  endproperty
  a_on: assert property (p_on) else $error("laser not restored"); // RL1
  property p_init; !init_done |-> !laser_on && tx_fault; endproperty
  a_init: assert property (p_init) else $error("init state wrong"); // RL3
  property p_init_end;
    init_done && $rose(init_done) && !$past(laser_fault_s) |-> !tx_fault;
  endproperty
  a_init_end: assert property (p_init_end) else $error("fault not cleared at init"); // RL3
  property p_fault; laser_fault_s |=> tx_fault && !tx_fault_oe; endproperty
  a_fault: assert property (p_fault) else $error("fault not raised"); // RL4
  property p_fault_clr; $fell(tx_fault) && $past(init_done) |-> $past(disable_held); endproperty
  a_fault_clr: assert property (p_fault_clr) else $error("fault cleared early"); // RL4
  property p_fault_pin;
    tx_fault && $past(tx_fault) |-> !tx_fault_oe && !tx_fault_out && !laser_on;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin wrong"); // RL5
  property p_los; $changed(rx_lost_s) |=> receive_signal_lost == $past(rx_lost_s); endproperty
  a_los: assert property (p_los) else $error("lost flag late"); // RL6
  property p_present; presence_oe && !presence_out; endproperty
  a_present: assert property (p_present) else $error("presence released"); // RL9
  property p_snap; twi_start |=> snap_all == $past(diag_all); endproperty
  a_snap: assert property (p_snap) else $error("monitor not captured"); // RL11

  c_read: cover property (state == optical_pkg::TW_ACK_READ ##1 state == optical_pkg::TW_READ);
  c_clear: cover property ($fell(tx_fault) && init_done);
  c_on: cover property ($rose(laser_on));
  c_los: cover property ($rose(receive_signal_lost));
endmodule // optical_module_control_status

// ### bench/host_model.sv
`timescale 1ns/1ps
module host_model #(
  parameter int HALF_NS = 1250
) (
  // serial lines
  output logic scl,
  output logic sda_low,
  input wire logic sda,
  // disable request
  output logic dis_en,
  output logic dis_val
);
  localparam int Q_NS = HALF_NS / 2;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    dis_en = 1'b1;
    dis_val = 1'b1;
  end
  // mode 2 lets the pin float
  task automatic set_disable(input logic [1:0] mode);
    dis_en = (mode != 2'h2);
    dis_val = mode[0];
  endtask
  // scl stays high between frames
  task automatic put_bit(input logic b);
    sda_low = !b;
    #Q_NS scl = 1'b1;
    #HALF_NS scl = 1'b0;
    #Q_NS;
  endtask
  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    #Q_NS scl = 1'b1;
    #Q_NS b = sda;
    #Q_NS scl = 1'b0;
    #Q_NS;
  endtask
  task automatic start_cond;
    sda_low = 1'b0;
    #Q_NS scl = 1'b1;
    #HALF_NS sda_low = 1'b1;
    #HALF_NS scl = 1'b0;
    #Q_NS;
  endtask
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i]);
    end
    get_bit(a);
    ack = !a;
  endtask
  task automatic read_byte(input logic [6:0] dev, input logic [7:0] ptr,
      output logic [7:0] v, output logic ack);
    logic a2;
    logic b;
    v = 8'h00;
    start_cond();
    put_byte({dev, 1'b0}, ack);
    if (ack) begin
      put_byte(ptr, a2);
      ack = ack & a2;
      start_cond();
      put_byte({dev, 1'b1}, a2);
      ack = ack & a2;
      for (int i = 7; i >= 0; i--) begin
        get_bit(b);
        v[i] = b;
      end
      put_bit(1'b1);
    end
    sda_low = 1'b1;
    #Q_NS scl = 1'b1;
    #HALF_NS sda_low = 1'b0;
    #HALF_NS;
  endtask
endmodule // host_model

// ### bench/tb_optical_module_control_status.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) begin \
      fail_count++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb_optical_module_control_status;
  localparam logic [7:0] ID_VAL = 8'h5a; // arbitrary value
  logic sys_clk, srst, fault_in, absent_in, cal_ext;
  logic [15:0] d_temp, d_vcc, d_bias, d_txp, d_rx;
  logic fault_out, fault_oe, lost_out, lost_oe, pres_out, pres_oe;
  logic sda_out, sda_oe, laser_on, scl, sda_low, dis_en, dis_val;
  logic [7:0] v;
  logic ack;
  int fail_count, n_checks;
  // module pull-up on the disable pin, host pull-up on sda
  wire tx_dis = dis_en ? dis_val : 1'b1;
  wire sda_line = !(sda_low || (sda_oe && !sda_out));
  optical_module_control_status #(.INIT_CYCLES(100), .ID_TYPE(ID_VAL)) i_dut (
    .sys_clk(sys_clk), .srst(srst), .tx_disable_pin(tx_dis),
    .tx_fault_out(fault_out), .tx_fault_oe(fault_oe),
    .receive_signal_lost_out(lost_out), .receive_signal_lost_oe(lost_oe),
    .presence_out(pres_out), .presence_oe(pres_oe), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .laser_fault_in(fault_in),
    .rx_signal_absent_in(absent_in), .laser_on(laser_on), .cal_external(cal_ext),
    .diag_temp(d_temp), .diag_vcc(d_vcc), .diag_bias(d_bias),
    .diag_tx_power(d_txp), .diag_rx_power(d_rx));
  host_model i_host (.scl(scl), .sda_low(sda_low), .sda(sda_line), .dis_en(dis_en),
    .dis_val(dis_val));
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic logic pick(input int s);
    return (s == 0) ? laser_on : (s == 1) ? fault_oe : lost_oe;
  endfunction
  task automatic wait_for(input int s, input logic val, input int bound, input string nm);
    int n;
    n = 0;
    while (pick(s) !== val && n < bound) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK(nm, val, pick(s))
    if (pick(s) !== val) close_out();
  endtask
  task automatic t_init;
    i_host.set_disable(2'h0);
    `CHK("presence", 2'b10, {pres_oe, pres_out})
    repeat (50) @(negedge sys_clk);
    `CHK("fault in init", 2'b00, {fault_oe, laser_on})
    wait_for(1, 1'b1, 200, "fault clear");
    wait_for(0, 1'b1, 10, "laser on");
    $display("init done");
  endtask
  task automatic t_disable;
    for (int m = 1; m <= 2; m++) begin
      i_host.set_disable(2'(m));
      wait_for(0, 1'b0, optical_pkg::OFF_CYCLES, "laser off");
      i_host.set_disable(2'h0);
      wait_for(0, 1'b1, optical_pkg::ON_CYCLES, "laser back");
    end
    $display("disable done");
  endtask
  task automatic t_fault;
    fault_in = 1'b1;
    wait_for(1, 1'b0, optical_pkg::FAULT_CYCLES, "fault shown");
    // laser register follows the fault flag one edge later
    @(negedge sys_clk);
    `CHK("laser in fault", 1'b0, laser_on)
    fault_in = 1'b0;
    repeat (100) @(negedge sys_clk);
    i_host.set_disable(2'h1);
    repeat (1000) @(negedge sys_clk);
    `CHK("short clear", 1'b0, fault_oe)
    repeat (optical_pkg::RESET_CYCLES - 1000) @(negedge sys_clk);
    wait_for(1, 1'b1, 50, "fault cleared");
    i_host.set_disable(2'h0);
    wait_for(0, 1'b1, optical_pkg::ON_CYCLES, "laser after clear");
    $display("fault done");
  endtask
  task automatic t_los;
    absent_in = 1'b1;
    wait_for(2, 1'b0, optical_pkg::LOS_CYCLES, "lost raised");
    absent_in = 1'b0;
    wait_for(2, 1'b1, optical_pkg::LOS_CYCLES, "lost cleared");
    $display("signal lost done");
  endtask
  task automatic t_serial;
    i_host.read_byte(optical_pkg::ID_DEV_ADDR, optical_pkg::ID_TYPE_ADDR, v, ack);
    `CHK("id type", {1'b1, ID_VAL}, {ack, v})
    i_host.read_byte(optical_pkg::ID_DEV_ADDR, optical_pkg::CAL_ADDR, v, ack);
    `CHK("cal ext", 3'b101, {ack, v[optical_pkg::CAL_INT_BIT], v[optical_pkg::CAL_EXT_BIT]})
    i_host.read_byte(optical_pkg::DIAG_DEV_ADDR, optical_pkg::DIAG_BASE, v, ack);
    `CHK("temp msb", 9'h11a, {ack, v})
    // new monitor values, taken at the next start
    {d_temp, d_vcc, d_bias, d_txp, d_rx} = 80'h2c3d_8102_0d0e_5f60_3b7e;
    i_host.read_byte(optical_pkg::DIAG_DEV_ADDR, 8'h69, v, ack);
    `CHK("rx lsb", 9'h17e, {ack, v})
    i_host.read_byte(7'h52, 8'h00, v, ack);
    `CHK("foreign address", 1'b0, ack)
    $display("serial done");
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    srst = 1'b1;
    fault_in = 1'b0;
    absent_in = 1'b0;
    cal_ext = 1'b1;
    {d_temp, d_vcc, d_bias, d_txp, d_rx} = 80'h1a2b_8001_0c0d_4e5f_9a7c;
    fail_count = 0;
    n_checks = 0;
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    t_init();
    t_disable();
    t_fault();
    t_los();
    t_serial();
    close_out();
  end
endmodule // tb_optical_module_control_status
